// >>> pkg/mlg_pkg.sv
// Purpose: shared constants and types for the modem level and gpio config block
// Assumes: 16-bit registers reached by 7-bit register index over the link
// Notes:   register offsets are the printed index values
package mlg_pkg;
    localparam logic [6:0]  REG_LINE1_LEVEL   = 7'h46;    // line 1 level control
    localparam logic [6:0]  REG_LINE2_LEVEL   = 7'h48;    // line 2 level control
    localparam logic [6:0]  REG_GPIO_DIR      = 7'h4C;    // gpio direction
    localparam logic [6:0]  REG_GPIO_POL      = 7'h4E;    // gpio polarity / type
    localparam logic [6:0]  REG_GPIO_EDGE     = 7'h50;    // gpio edge select
    localparam logic [6:0]  REG_GPIO_STATE    = 7'h54;    // gpio pin state
    localparam logic [15:0] LEVEL_RESET_ON    = 16'h8080; // both paths muted
    localparam logic [15:0] LEVEL_RESET_OFF   = 16'h0000; // unmuted, 0 dB
    localparam logic [15:0] LEVEL_MASK        = 16'h8E8E; // writable level bits
    localparam logic [15:0] DIR_RESET_LINE1   = 16'h003F; // line 1 direction reset
    localparam logic [15:0] DIR_RESET_LINE2   = 16'hFC00; // line 2 direction reset
    localparam logic [15:0] GPIO_IMPL_MASK    = 16'hFC3F; // implemented gpio slots
    localparam logic [15:0] EDGE_IMPL_MASK    = 16'hE83A; // slots that may be sticky
    localparam logic [15:0] POL_RESET         = 16'hFFFF; // soft reset value
    localparam logic [15:0] EDGE_RESET        = 16'h0000; // cold reset value
    localparam int          TX_MUTE_BIT       = 15;       // transmit mute
    localparam int          RX_MUTE_BIT       = 7;        // receive mute
    localparam int          TX_ATT_LSB        = 9;        // transmit attenuation lsb
    localparam int          RX_GAIN_LSB       = 1;        // receive gain lsb
    localparam logic [3:0]  DB_0              = 4'h0;     // 0 dB
    localparam logic [3:0]  DB_3              = 4'h3;     // 3 dB
    localparam logic [3:0]  DB_6              = 4'h6;     // 6 dB
    localparam logic [3:0]  DB_9              = 4'h9;     // 9 dB
    localparam logic [3:0]  DB_12             = 4'hC;     // 12 dB

    // link-side level change announce state
    typedef enum logic [1:0] {
        MLG_IDLE,
        MLG_WAIT
    } mlg_xfer_t;
endpackage

// >>> pkg/mlg_lvl_if.sv
// Purpose: carries one line's decoded level settings
// Assumes: driven by one level decoder instance
// Notes:   dB values in whole decibels
`timescale 1ns/100ps
interface mlg_lvl_if;
    logic       tx_mute;  // transmit muted
    logic       rx_mute;  // receive muted
    logic [3:0] tx_att;   // transmit attenuation in dB
    logic [3:0] rx_gain;  // receive gain in dB
    modport src (output tx_mute, rx_mute, tx_att, rx_gain);
    modport dst (input  tx_mute, rx_mute, tx_att, rx_gain);
endinterface

// >>> rtl/mlg_level_dec.sv
// Purpose: decodes one level register into mute and dB settings
// Assumes: register value already masked
// Notes:   registered, one cycle behind the register
`timescale 1ns/100ps
module mlg_level_dec
    import mlg_pkg::*;
(
    input  wire logic        clk,     // system clock
    input  wire logic        reset_n, // synchronous reset, active low
    input  wire logic [15:0] level,   // level register contents
    mlg_lvl_if.src           lvl      // decoded settings
);
    typedef struct packed {
        logic       tx_mute;
        logic       rx_mute;
        logic [3:0] tx_att;
        logic [3:0] rx_gain;
    } mlg_dec_t;

    mlg_dec_t st;       // registered state
    mlg_dec_t next_st;  // next state

    // maps a 3-bit code to dB, top bit set gives 12 dB
    function automatic logic [3:0] code_db(input logic [2:0] code);
        logic [3:0] db;
        db = DB_12;
        case (code)
            3'h0: db = DB_0;
            3'h1: db = DB_3;
            3'h2: db = DB_6;
            3'h3: db = DB_9;
            default: db = DB_12;
        endcase
        return db;
    endfunction

    // decode mute bits and fields
    always_comb begin
        next_st         = st;
        next_st.tx_mute = level[TX_MUTE_BIT];
        next_st.rx_mute = level[RX_MUTE_BIT];
        next_st.tx_att  = code_db(level[TX_ATT_LSB +: 3]);
        next_st.rx_gain = code_db(level[RX_GAIN_LSB +: 3]);
    end

    // register the decoded values
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign lvl.tx_mute = st.tx_mute;
    assign lvl.rx_mute = st.rx_mute;
    assign lvl.tx_att  = st.tx_att;
    assign lvl.rx_gain = st.rx_gain;
endmodule

// >>> rtl/mlg_regs.sv
// Purpose: modem level and virtual gpio configuration registers
// Assumes: register writes and slot 12 bits arrive on the link clock
// Notes:   register file lives in the link domain; levels cross to clk
//
// Function
// - line 1 level resets per line strap
// - line 2 level resets per line strap
// - bit 15 tx mute, bit 7 rx mute
// - tx attenuation code to 0..12 dB
// - rx gain code to 0..12 dB
// - direction bit one input, zero output
// - direction resets per line strap
// - gpio values travel in slot 12
// - input polarity: zero low, one high
// - output type: zero push-pull, one open-drain
// - polarity reset only by soft reset
// - unimplemented polarity bits read one
// - sticky bit selects edge latched input
// - latched input cleared only by zero write
// - edge select cold reset zero, unimplemented zero
// - sticky transition sets status until cleared
`timescale 1ns/100ps
module mlg_regs
    import mlg_pkg::*;
(
    input  wire logic        clk,           // system clock, 50 MHz
    input  wire logic        reset_n,       // synchronous reset, active low
    input  wire logic        link_clk,      // ac-link bit clock
    input  wire logic        link_reset_n,  // cold register reset, link domain, low
    input  wire logic        warm_reset_n,  // warm register reset, link domain, low
    input  wire logic        soft_reset,    // soft register reset strobe, link domain
    input  wire logic        line2_sel,     // strap: 1 configures the line 2 device
    input  wire logic        wr_en,         // register write strobe, link domain
    input  wire logic [6:0]  wr_addr,       // register write index
    input  wire logic [15:0] wr_data,       // register write data
    input  wire logic [6:0]  rd_addr,       // register read index
    output logic      [15:0] rd_data,       // read data for addressed register
    input  wire logic        frame_strobe,  // slot 12 valid, once per frame
    input  wire logic [15:0] slot12_out,    // outgoing slot 12 gpio levels
    input  wire logic [15:0] gpio_pin_in,   // virtual input pin levels
    output logic      [15:0] slot12_in,     // incoming slot 12 pin state
    output logic      [15:0] gpio_drive,    // output value per pin
    output logic      [15:0] gpio_oe,       // output enable per pin
    output logic             l1_tx_mute,    // line 1 transmit mute
    output logic             l1_rx_mute,    // line 1 receive mute
    output logic      [3:0]  l1_tx_att,     // line 1 attenuation dB
    output logic      [3:0]  l1_rx_gain,    // line 1 gain dB
    output logic             l2_tx_mute,    // line 2 transmit mute
    output logic             l2_rx_mute,    // line 2 receive mute
    output logic      [3:0]  l2_tx_att,     // line 2 attenuation dB
    output logic      [3:0]  l2_rx_gain     // line 2 gain dB
);
    // link domain register state
    typedef struct packed {
        logic        strap_done;   // strap captured after reset
        logic        line2;        // captured line strap
        logic [15:0] line1_level;  // line1_level_ctrl
        logic [15:0] line2_level;  // line2_level_ctrl
        logic [15:0] gpio_dir;     // gpio_direction
        logic [15:0] gpio_pol;     // gpio_polarity_type
        logic [15:0] gpio_edge;    // gpio_edge_select
        logic [15:0] pin_s1;       // input pin sync stage one
        logic [15:0] pin_s2;       // input pin sync stage two
        logic [15:0] out_lvl;      // output levels of the last frame
        logic [15:0] pin_prev;     // last frame's normalised input
        logic [15:0] pin_state;    // gpio pin state
        logic [15:0] rd_data;      // read data
        logic [15:0] slot12_in;    // incoming slot 12
        logic [15:0] drive;        // output levels
        logic [15:0] oe;           // output enables
        logic        tog;          // toggles when levels change
        mlg_xfer_t   xfer;         // level update state
    } mlg_link_t;

    // system domain state
    typedef struct packed {
        logic        tog_s1;       // toggle sync stage one
        logic        tog_s2;       // toggle sync stage two
        logic        tog_s3;       // toggle edge reference
        logic [15:0] l1;           // captured line 1 level
        logic [15:0] l2;           // captured line 2 level
    } mlg_sys_t;

    mlg_link_t lk;       // link registers
    mlg_link_t next_lk;  // link next value
    mlg_sys_t  sy;       // system registers
    mlg_sys_t  next_sy;  // system next value

    logic [15:0] norm_in;      // input levels with polarity applied
    logic [15:0] sticky_evt;   // edge seen on sticky inputs
    logic [15:0] is_in;        // pins configured as input

    // link domain next state
    always_comb begin
        next_lk    = lk;
        is_in      = lk.gpio_dir & GPIO_IMPL_MASK;
        // two-stage synchroniser for the input pins
        next_lk.pin_s1 = gpio_pin_in;
        next_lk.pin_s2 = lk.pin_s1;
        // polarity zero means active low, so invert those inputs
        norm_in    = lk.pin_s2 ~^ lk.gpio_pol;
        sticky_evt = '0;
        // catch the strap one cycle after cold reset release
        if (!lk.strap_done) begin
            next_lk.strap_done = 1'b1;
            next_lk.line2      = line2_sel;
            next_lk.line1_level = line2_sel ? LEVEL_RESET_OFF : LEVEL_RESET_ON;
            next_lk.line2_level = line2_sel ? LEVEL_RESET_ON : LEVEL_RESET_OFF;
            next_lk.gpio_dir    = line2_sel ? DIR_RESET_LINE2 : DIR_RESET_LINE1;
        end
        // register writes
        if (wr_en && lk.strap_done) begin
            case (wr_addr)
                REG_LINE1_LEVEL: next_lk.line1_level = wr_data & LEVEL_MASK;
                REG_LINE2_LEVEL: next_lk.line2_level = wr_data & LEVEL_MASK;
                REG_GPIO_DIR:    next_lk.gpio_dir    = wr_data & GPIO_IMPL_MASK;
                REG_GPIO_POL:    next_lk.gpio_pol    = wr_data | ~GPIO_IMPL_MASK;
                REG_GPIO_EDGE:   next_lk.gpio_edge   = wr_data & EDGE_IMPL_MASK;
                default: begin
                end
            endcase
        end
        // per-frame slot 12 processing
        if (frame_strobe) begin
            next_lk.pin_prev = norm_in;
            // output levels are taken only while the slot 12 word is valid
            next_lk.out_lvl  = slot12_out;
            // edge on a sticky input latches; level inputs follow the pin
            sticky_evt = (norm_in ^ lk.pin_prev) & is_in & lk.gpio_edge;
        end
        // writing zero clears a latched bit; a new edge wins the same cycle
        if (wr_en && lk.strap_done && wr_addr == REG_GPIO_STATE) begin
            next_lk.pin_state = lk.pin_state & (wr_data | ~lk.gpio_edge);
        end
        next_lk.pin_state = (next_lk.pin_state & lk.gpio_edge & is_in)
                          | sticky_evt
                          | (norm_in & is_in & ~lk.gpio_edge)
                          | (lk.out_lvl & ~is_in);
        next_lk.pin_state = next_lk.pin_state & GPIO_IMPL_MASK;
        next_lk.slot12_in = lk.pin_state;
        // outputs hold the last frame's slot 12 level, never the idle bus
        next_lk.drive = lk.out_lvl & ~is_in & GPIO_IMPL_MASK;
        // open drain drives only lows; push-pull drives always
        next_lk.oe = ~is_in & GPIO_IMPL_MASK
                   & (~lk.gpio_pol | ~lk.out_lvl);
        // read mux
        case (rd_addr)
            REG_LINE1_LEVEL: next_lk.rd_data = lk.line1_level;
            REG_LINE2_LEVEL: next_lk.rd_data = lk.line2_level;
            REG_GPIO_DIR:    next_lk.rd_data = lk.gpio_dir;
            REG_GPIO_POL:    next_lk.rd_data = lk.gpio_pol | ~GPIO_IMPL_MASK;
            REG_GPIO_EDGE:   next_lk.rd_data = lk.gpio_edge & EDGE_IMPL_MASK;
            REG_GPIO_STATE:  next_lk.rd_data = lk.pin_state;
            default:         next_lk.rd_data = '0;
        endcase
        // announce a level change to the system domain
        case (lk.xfer)
            MLG_IDLE: begin
                if (next_lk.line1_level != lk.line1_level ||
                    next_lk.line2_level != lk.line2_level) begin
                    next_lk.xfer = MLG_WAIT;
                end
            end
            MLG_WAIT: begin
                next_lk.tog  = ~lk.tog;
                next_lk.xfer = MLG_IDLE;
            end
            default: next_lk.xfer = MLG_IDLE;
        endcase
    end

    // link domain registers with cold, warm and soft resets
    always_ff @(posedge link_clk) begin
        if (!link_reset_n) begin
            // cold reset keeps the polarity register intact
            lk          <= '0;
            lk.gpio_pol <= lk.gpio_pol;
            lk.gpio_edge <= EDGE_RESET;
        end else if (!warm_reset_n) begin
            lk          <= next_lk;
            lk.gpio_pol <= lk.gpio_pol;
        end else if (soft_reset) begin
            lk          <= next_lk;
            lk.gpio_pol <= POL_RESET;
        end else begin
            lk <= next_lk;
        end
    end

    // system domain: sync the toggle, then copy the stable levels
    always_comb begin
        next_sy        = sy;
        next_sy.tog_s1 = lk.tog;
        next_sy.tog_s2 = sy.tog_s1;
        next_sy.tog_s3 = sy.tog_s2;
        // levels were stable one link cycle before the toggle moved
        if (sy.tog_s2 != sy.tog_s3) begin
            next_sy.l1 = lk.line1_level;
            next_sy.l2 = lk.line2_level;
        end
    end

    // system domain registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sy <= '0;
        end else begin
            sy <= next_sy;
        end
    end

    mlg_lvl_if l1_if ();  // line 1 decoded levels
    mlg_lvl_if l2_if ();  // line 2 decoded levels

    // line 1 level decode
    mlg_level_dec u_l1 (
        .clk     (clk),
        .reset_n (reset_n),
        .level   (sy.l1),
        .lvl     (l1_if)
    );

    // line 2 level decode
    mlg_level_dec u_l2 (
        .clk     (clk),
        .reset_n (reset_n),
        .level   (sy.l2),
        .lvl     (l2_if)
    );

    assign rd_data    = lk.rd_data;
    assign slot12_in  = lk.slot12_in;
    assign gpio_drive = lk.drive;
    assign gpio_oe    = lk.oe;
    assign l1_tx_mute = l1_if.tx_mute;
    assign l1_rx_mute = l1_if.rx_mute;
    assign l1_tx_att  = l1_if.tx_att;
    assign l1_rx_gain = l1_if.rx_gain;
    assign l2_tx_mute = l2_if.tx_mute;
    assign l2_rx_mute = l2_if.rx_mute;
    assign l2_tx_att  = l2_if.tx_att;
    assign l2_rx_gain = l2_if.rx_gain;
endmodule

// >>> tb/mlg_ctl_model.sv
// Purpose: link controller model driving register and slot 12 traffic
// Assumes: requests launch just after link clock rising edges
// Notes:   idle request lines show the inverse of their last value
`timescale 1ns/100ps
module mlg_ctl_model
    import mlg_pkg::*;
(
    input  wire logic        link_clk,     // ac-link bit clock
    input  wire logic [15:0] rd_data,      // register read data
    output logic             wr_en,        // write strobe
    output logic      [6:0]  wr_addr,      // write index
    output logic      [15:0] wr_data,      // write data
    output logic      [6:0]  rd_addr,      // read index
    output logic             frame_strobe, // slot 12 valid
    output logic      [15:0] slot12_out    // outgoing gpio levels
);
    // idle values at time zero
    initial begin
        wr_en = 1'b0;
        wr_addr = 7'h00;
        wr_data = 16'h0000;
        rd_addr = REG_GPIO_DIR;
        frame_strobe = 1'b0;
        slot12_out = 16'h0000;
    end
    // one write, then idle edges so level writes never merge
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge link_clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge link_clk);
        wr_en <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
        @(posedge link_clk);
    endtask
    // hold the index, take data one edge after it is registered
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge link_clk);
        rd_addr <= a;
        repeat (2) @(posedge link_clk);
        d = rd_data;
    endtask
    // gpio outputs are set only through the slot 12 word
    task automatic frame(input logic [15:0] s);
        // two idle edges let a new pin level through the synchroniser
        repeat (2) @(posedge link_clk);
        frame_strobe <= 1'b1;
        slot12_out <= s;
        @(posedge link_clk);
        frame_strobe <= 1'b0;
        slot12_out <= ~s;
        repeat (3) @(posedge link_clk);
    endtask
endmodule

// >>> tb/mlg_regs_chk.sv
// Purpose: port checker for the level and gpio register block
// Assumes: level outputs settle within 14 clk cycles of a change
// Notes:   bound to every mlg_regs instance
`timescale 1ns/100ps
module mlg_regs_chk
    import mlg_pkg::*;
(
    input wire logic        clk,          // system clock
    input wire logic        reset_n,      // system reset, low
    input wire logic        link_clk,     // link clock
    input wire logic        link_reset_n, // cold reset, low
    input wire logic        line2_sel,    // line strap
    input wire logic        wr_en,        // write strobe
    input wire logic [6:0]  wr_addr,      // write index
    input wire logic [15:0] wr_data,      // write data
    input wire logic [6:0]  rd_addr,      // read index
    input wire logic [15:0] rd_data,      // read data
    input wire logic        l1_tx_mute,   // line 1 tx mute
    input wire logic        l1_rx_mute,   // line 1 rx mute
    input wire logic [3:0]  l1_tx_att,    // line 1 attenuation
    input wire logic [3:0]  l1_rx_gain,   // line 1 gain
    input wire logic        l2_tx_mute,   // line 2 tx mute
    input wire logic        l2_rx_mute,   // line 2 rx mute
    input wire logic [3:0]  l2_tx_att,    // line 2 attenuation
    input wire logic [3:0]  l2_rx_gain    // line 2 gain
);
    logic [15:0] e1, e2; // expected level words, link side
    logic [15:0] s1, s2; // clk-side copies
    logic [3:0]  cnt;    // clk cycles since last change
    // dB for a 3-bit code, top bit set gives 12 dB
    function automatic logic [3:0] db(input logic [2:0] c);
        return c[2] ? DB_12 : (c[1] ? (c[0] ? DB_9 : DB_6) : (c[0] ? DB_3 : DB_0));
    endfunction
    // follow level writes and strap resets
    always_ff @(posedge link_clk) begin
        if (!link_reset_n) begin
            e1 <= line2_sel ? 16'h0000 : 16'h8080;
            e2 <= line2_sel ? 16'h8080 : 16'h0000;
        end else if (wr_en && wr_addr == REG_LINE1_LEVEL) begin
            e1 <= wr_data & LEVEL_MASK;
        end else if (wr_en && wr_addr == REG_LINE2_LEVEL) begin
            e2 <= wr_data & LEVEL_MASK;
        end
    end
    // restart the settle count on any change or reset
    always_ff @(posedge clk) begin
        s1 <= e1;
        s2 <= e2;
        if (!reset_n || !link_reset_n || s1 != e1 || s2 != e2) begin
            cnt <= 4'h0;
        end else if (cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
        end
    end
    property p_l1_mute;
        @(posedge clk) disable iff (!reset_n)
        cnt == 4'hE |-> l1_tx_mute == s1[TX_MUTE_BIT] && l1_rx_mute == s1[RX_MUTE_BIT];
    endproperty
    a_l1_mute: assert property (p_l1_mute) else $error("line 1 mute wrong");
    property p_l1_att;
        @(posedge clk) disable iff (!reset_n) cnt == 4'hE |-> l1_tx_att == db(s1[11:9]);
    endproperty
    a_l1_att: assert property (p_l1_att) else $error("line 1 attenuation wrong");
    property p_l1_gain;
        @(posedge clk) disable iff (!reset_n) cnt == 4'hE |-> l1_rx_gain == db(s1[3:1]);
    endproperty
    a_l1_gain: assert property (p_l1_gain) else $error("line 1 gain wrong");
    property p_l2_lvl;
        @(posedge clk) disable iff (!reset_n) cnt == 4'hE |->
        {l2_tx_mute, l2_rx_mute, l2_tx_att, l2_rx_gain} == {s2[15], s2[7], db(s2[11:9]), db(s2[3:1])};
    endproperty
    a_l2_lvl: assert property (p_l2_lvl) else $error("line 2 levels wrong");
    property p_rsv;
        @(posedge link_clk) disable iff (!link_reset_n)
        rd_addr == REG_LINE1_LEVEL || rd_addr == REG_LINE2_LEVEL |=> (rd_data & ~LEVEL_MASK) == 16'h0000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved level bits set");
    property p_pol_unimpl;
        @(posedge link_clk) disable iff (!link_reset_n)
        rd_addr == REG_GPIO_POL |=> (rd_data | 16'hFC3F) == 16'hFFFF;
    endproperty
    a_pol_unimpl: assert property (p_pol_unimpl) else $error("polarity spare bits not one");
    property p_edge_unimpl;
        @(posedge link_clk) disable iff (!link_reset_n)
        rd_addr == REG_GPIO_EDGE |=> (rd_data & 16'h17C5) == 16'h0000;
    endproperty
    a_edge_unimpl: assert property (p_edge_unimpl) else $error("edge spare bits set");
    property p_dir_reset;
        @(posedge link_clk) disable iff (!link_reset_n) $rose(link_reset_n) ##3
        rd_addr == REG_GPIO_DIR |=> rd_data == (line2_sel ? 16'hFC00 : 16'h003F);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction reset wrong");
endmodule
bind mlg_regs mlg_regs_chk u_chk (
    .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .link_reset_n(link_reset_n),
    .line2_sel(line2_sel), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .l1_tx_mute(l1_tx_mute), .l1_rx_mute(l1_rx_mute),
    .l1_tx_att(l1_tx_att), .l1_rx_gain(l1_rx_gain), .l2_tx_mute(l2_tx_mute),
    .l2_rx_mute(l2_rx_mute), .l2_tx_att(l2_tx_att), .l2_rx_gain(l2_rx_gain)
);

// >>> tb/tb.sv
// Purpose: self-checking bench for the level and gpio register block
// Assumes: the controller model issues every link request
// Notes:   levels are judged at the clk-domain outputs
`timescale 1ns/100ps
module tb;
    import mlg_pkg::*;
    logic        clk, reset_n, link_clk, link_reset_n, warm_reset_n, soft_reset, line2_sel;
    logic        wr_en, frame_strobe, l1_tx_mute, l1_rx_mute, l2_tx_mute, l2_rx_mute;
    logic [6:0]  wr_addr, rd_addr;
    logic [15:0] wr_data, rd_data, slot12_out, gpio_pin_in, slot12_in, gpio_drive, gpio_oe, v;
    logic [3:0]  l1_tx_att, l1_rx_gain, l2_tx_att, l2_rx_gain;
    logic [3:0]  dbt [8];     // dB per code
    int          miscompares; // mismatches
    int          checks;      // comparisons
    wire  [15:0] lvl1 = {6'h00, l1_tx_mute, l1_rx_mute, l1_tx_att, l1_rx_gain}; // line 1 view
    wire  [15:0] lvl2 = {6'h00, l2_tx_mute, l2_rx_mute, l2_tx_att, l2_rx_gain}; // line 2 view
    wire  [15:0] pins = {11'h000, gpio_drive[0], gpio_oe[1:0], slot12_in[3], slot12_in[1]};
    mlg_regs DUT (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .link_reset_n(link_reset_n),
        .warm_reset_n(warm_reset_n), .soft_reset(soft_reset), .line2_sel(line2_sel),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
        .rd_data(rd_data), .frame_strobe(frame_strobe), .slot12_out(slot12_out),
        .gpio_pin_in(gpio_pin_in), .slot12_in(slot12_in), .gpio_drive(gpio_drive),
        .gpio_oe(gpio_oe), .l1_tx_mute(l1_tx_mute), .l1_rx_mute(l1_rx_mute),
        .l1_tx_att(l1_tx_att), .l1_rx_gain(l1_rx_gain), .l2_tx_mute(l2_tx_mute),
        .l2_rx_mute(l2_rx_mute), .l2_tx_att(l2_tx_att), .l2_rx_gain(l2_rx_gain));
    mlg_ctl_model ctl (.link_clk(link_clk), .rd_data(rd_data), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
        .frame_strobe(frame_strobe), .slot12_out(slot12_out));
    // system clock, 20 ns
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // link clock, 30 ns, offset in phase
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // compare one value and count it
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // read a register and compare the bits selected by mask m
    task automatic rdchk(input logic [6:0] a, input logic [15:0] e, input logic [15:0] m);
        logic [15:0] d;
        ctl.rd(a, d);
        chk($sformatf("reg %h", a), e & m, d & m);
    endtask
    // print counts and verdict, end the run
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        reset_n = 1'b0;
        link_reset_n = 1'b0;
        warm_reset_n = 1'b1;
        soft_reset = 1'b0;
        line2_sel = 1'b0;
        gpio_pin_in = 16'h0000;
        dbt = '{DB_0, DB_3, DB_6, DB_9, DB_12, DB_12, DB_12, DB_12};
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge link_clk);
        link_reset_n <= 1'b1;
        repeat (3) @(posedge link_clk);
        soft_reset <= 1'b1;
        @(posedge link_clk);
        soft_reset <= 1'b0;
        rdchk(REG_LINE1_LEVEL, 16'h8080, 16'hFFFF);
        rdchk(REG_LINE2_LEVEL, 16'h0000, 16'hFFFF);
        rdchk(REG_GPIO_DIR, 16'h003F, 16'hFFFF);
        rdchk(REG_GPIO_POL, 16'hFFFF, 16'hFFFF);
        rdchk(REG_GPIO_EDGE, 16'h0000, 16'hFFFF);
        // every code on both lines, mutes alternating
        for (int i = 0; i < 8; i++) begin
            v = {i[0], 3'h0, 3'(i), 1'b0, ~i[0], 3'h0, 3'(7 - i), 1'b0};
            ctl.wr(REG_LINE1_LEVEL, v);
            ctl.wr(REG_LINE2_LEVEL, ~v);
            repeat (14) @(posedge clk);
            chk("line 1 levels", {6'h00, v[15], v[7], dbt[i], dbt[7 - i]}, lvl1);
            chk("line 2 levels", {6'h00, ~v[15], ~v[7], dbt[7 - i], dbt[i]}, lvl2);
        end
        ctl.wr(REG_LINE1_LEVEL, 16'hFFFF);
        rdchk(REG_LINE1_LEVEL, 16'h8E8E, 16'hFFFF);
        ctl.wr(7'h4A, 16'h0000);
        rdchk(REG_LINE1_LEVEL, 16'h8E8E, 16'hFFFF);
        ctl.wr(REG_GPIO_EDGE, 16'hFFFF);
        rdchk(REG_GPIO_EDGE, 16'hE83A, 16'hFFFF);
        ctl.wr(REG_GPIO_POL, 16'h0000);
        rdchk(REG_GPIO_POL, 16'h03C0, 16'hFFFF);
        @(posedge link_clk);
        warm_reset_n <= 1'b0;
        repeat (2) @(posedge link_clk);
        warm_reset_n <= 1'b1;
        rdchk(REG_GPIO_POL, 16'h03C0, 16'hFFFF);
        // bit 0 output, bit 1 sticky high input, bit 3 level low input
        ctl.wr(REG_GPIO_POL, 16'h0002);
        ctl.wr(REG_GPIO_EDGE, 16'h0002);
        ctl.frame(16'h0001);
        ctl.wr(REG_GPIO_DIR, 16'h000A);
        ctl.frame(16'h0001);
        chk("gpio", 16'h0016, pins);
        gpio_pin_in <= gpio_pin_in ^ 16'h000A;
        ctl.frame(16'h0001);
        chk("gpio", 16'h0015, pins);
        gpio_pin_in <= gpio_pin_in ^ 16'h000A;
        ctl.frame(16'h0001);
        chk("gpio", 16'h0017, pins);
        rdchk(REG_GPIO_STATE, 16'h0002, 16'h0002);
        ctl.wr(REG_GPIO_STATE, 16'h0000);
        rdchk(REG_GPIO_STATE, 16'h0000, 16'h0002);
        ctl.wr(REG_GPIO_POL, 16'h0003);
        ctl.frame(16'h0001);
        chk("gpio", 16'h0012, pins);
        ctl.frame(16'h0000);
        chk("gpio", 16'h0006, pins);
        // cold reset as the line 2 device
        ctl.rd(REG_GPIO_DIR, v);
        @(posedge link_clk);
        line2_sel <= ~line2_sel;
        link_reset_n <= 1'b0;
        repeat (2) @(posedge link_clk);
        link_reset_n <= 1'b1;
        repeat (3) @(posedge link_clk);
        rdchk(REG_LINE1_LEVEL, 16'h0000, 16'hFFFF);
        rdchk(REG_LINE2_LEVEL, 16'h8080, 16'hFFFF);
        rdchk(REG_GPIO_DIR, 16'hFC00, 16'hFFFF);
        rdchk(REG_GPIO_POL, 16'h03C3, 16'hFFFF);
        repeat (20) @(posedge clk);
        close_out();
    end
    // watchdog far beyond the expected run length
    initial begin
        #200000;
        miscompares++;
        close_out();
    end
endmodule
